// File: core/range_cfg_pkg.sv
// Package: register map, field layout and reset values for the range decode block
package range_cfg_pkg;

    // Register offsets (byte addresses in configuration space)
    localparam logic [7:0]  OFF_IO_WINDOW_TWO   = 8'hA0;
    localparam logic [7:0]  OFF_INTR_UNIT_WIN   = 8'hA4;
    localparam logic [7:0]  OFF_RESET_STRAP     = 8'hB0;

    // Reset values
    localparam logic [31:0] IOW2_RESET_COMPAT   = 32'hFFF00001;
    localparam logic [31:0] IOW2_RESET_AUX      = 32'hFFF00000;
    localparam logic [31:0] IUW_RESET_COMPAT    = 32'h00FEC001;
    localparam logic [31:0] IUW_RESET_AUX       = 32'h00FEC000;
    localparam logic [15:0] STRAP_RESET         = 16'h0000;

    // Writable bit masks; reserved bits read zero
    localparam logic [31:0] IOW2_WMASK          = 32'hFFF0FFF1;
    localparam logic [31:0] IUW_WMASK           = 32'h0FFFFFF1;
    localparam logic [15:0] STRAP_WMASK_FULL    = 16'h1FE0;
    localparam logic [15:0] STRAP_WMASK_SINGLE  = 16'h1AE0;

    // Field positions
    localparam int IOW2_END_HI   = 31;
    localparam int IOW2_END_LO   = 20;
    localparam int IOW2_START_HI = 15;
    localparam int IOW2_START_LO = 4;
    localparam int IOW2_EN_BIT   = 0;
    localparam int IUW_BASE_HI   = 27;
    localparam int IUW_BASE_LO   = 12;
    localparam int IUW_LOW_HI    = 11;
    localparam int IUW_LOW_LO    = 8;
    localparam int IUW_HIGH_HI   = 7;
    localparam int IUW_HIGH_LO   = 4;
    localparam int IUW_EN_BIT    = 0;
    localparam int STRAP_HI      = 12;
    localparam int STRAP_LO      = 5;

    // Bridge variants
    typedef enum logic [1:0] {
        BRIDGE_SINGLE,
        BRIDGE_COMPAT,
        BRIDGE_AUX
    } bridge_role_t;

    // Configuration register access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    // Decode query from either bus
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [35:0] addr;
    } dec_req_t;

endpackage : range_cfg_pkg

// File: core/range_decode_cfg.sv
// Bridge range decode for I/O window two and interrupt unit window, plus reset straps
`timescale 1ns/100ps
// Functional notes
// RULE1: Window two end field in bits 31:20 compares with I/O address 15:4.
// RULE2: Window two start field in bits 15:4 compares with I/O address 15:4.
// RULE3: Enable 1 sends host I/O in range to PCI; 0 forwards PCI instead.
// RULE4: Outside windows compat bridge forwards host I/O; auxiliary forwards PCI.
// RULE5: Window two resets FFF00001h compat, FFF00000h auxiliary.
// RULE6: Software programs identical window two limits in both bridges.
// RULE7: Enabled unit window claims base+low*4K up to base+high*4K+FFFh.
// RULE8: Unit window base in bits 27:12 matches address 35:20; 31:28 read zero.
// RULE9: Lowest unit ID in bits 11:8, highest unit ID in bits 7:4.
// RULE10: Unit window enable is bit 0; resets 00FEC001h compat/single, 00FEC000h aux.
// RULE11: System places at most 16 units contiguously in a 64 KB window.
// RULE12: Software gives all bridges same base and covers whole 64 KB window.
// RULE13: Power-on reset loads strap register 00h and drives it on address lines.
// RULE14: Programmed hard reset keeps strap contents and drives them during host reset.
// RULE15: Auxiliary bridge does not implement the strap register.
// RULE16: Strap bits 12:11 cluster ID drive address lines 12:11 during reset.
// RULE17: Strap bit 10 bus-init enable drives line 10; reserved on single bridge.
// RULE18: Strap bit 9 bus-error enable drives address line 9.
// RULE19: Strap bit 8 address-parity error enable drives line 8; reserved on single.
// RULE20: Strap bit 7 selects queue depth 8 or 1, drives address line 7.
// RULE21: Strap bit 6 selects reset vector 1 MB or 4 GB, drives line 6.
// RULE22: Strap bit 5 enables redundancy check mode, drives address line 5.
// RULE23: Address inside window two when start <= A[15:4] <= end.
module range_decode_cfg
    import range_cfg_pkg::*;
#(
    parameter bridge_role_t ROLE = BRIDGE_COMPAT
) (
    // Clock and power-on reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // Programmed hard reset in progress (host reset asserted by bridge)
    input  wire logic         hard_reset_i,
    // Configuration register access
    input  wire cfg_req_t     cfg_i,
    output logic [31:0]       cfg_rdata_o,
    output logic              cfg_ack_o,
    // Host bus decode query and answer
    input  wire dec_req_t     host_i,
    output logic              host_to_pci_o,
    output logic              host_done_o,
    // PCI bus decode query and answer
    input  wire dec_req_t     pci_i,
    output logic              pci_to_host_o,
    output logic              pci_done_o,
    // Strap values onto host address lines 12:5 during host reset
    output logic [12:5]       strap_addr_o,
    output logic [12:5]       strap_addr_oe_o
);

    localparam logic IS_AUX   = (ROLE == BRIDGE_AUX);
    localparam logic HAS_STRAP = !IS_AUX;
    localparam logic [15:0] STRAP_WMASK =
        (ROLE == BRIDGE_SINGLE) ? STRAP_WMASK_SINGLE : STRAP_WMASK_FULL;
    localparam logic [31:0] IOW2_RESET = IS_AUX ? IOW2_RESET_AUX : IOW2_RESET_COMPAT;
    localparam logic [31:0] IUW_RESET  = IS_AUX ? IUW_RESET_AUX  : IUW_RESET_COMPAT;

    logic [31:0] io_window_two;
    logic [31:0] interrupt_unit_window;
    logic [15:0] reset_strap_values;
    logic [31:0] be_mask;
    logic [31:0] next_rdata;

    // Byte-enable expansion, one lane per byte
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign be_mask[g*8 +: 8] = {8{cfg_i.be[g]}};
        end
    endgenerate

    // RULE5: window two reset per role
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            io_window_two <= IOW2_RESET;
        end else if (cfg_i.wr && cfg_i.addr == OFF_IO_WINDOW_TWO) begin
            io_window_two <= (io_window_two & ~(be_mask & IOW2_WMASK))
                           | (cfg_i.wdata & be_mask & IOW2_WMASK);
        end
    end

    // RULE10: unit window reset per role; RULE8 reserved top nibble kept zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            interrupt_unit_window <= IUW_RESET;
        end else if (cfg_i.wr && cfg_i.addr == OFF_INTR_UNIT_WIN) begin
            interrupt_unit_window <= (interrupt_unit_window & ~(be_mask & IUW_WMASK))
                                   | (cfg_i.wdata & be_mask & IUW_WMASK);
        end
    end

    // RULE13: power-on reset loads default; RULE14 hard reset does not touch it
    // RULE15: absent on auxiliary bridge, stays zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reset_strap_values <= STRAP_RESET;
        end else if (HAS_STRAP && cfg_i.wr && cfg_i.addr == OFF_RESET_STRAP) begin
            reset_strap_values <= (reset_strap_values & ~(be_mask[15:0] & STRAP_WMASK))
                                | (cfg_i.wdata[15:0] & be_mask[15:0] & STRAP_WMASK);
        end
    end

    // Read mux; unmapped offsets and absent register read zero
    always_comb begin
        next_rdata = 32'h00000000;
        case (cfg_i.addr)
            OFF_IO_WINDOW_TWO: next_rdata = io_window_two;
            OFF_INTR_UNIT_WIN: next_rdata = interrupt_unit_window;
            OFF_RESET_STRAP:   next_rdata = {16'h0000, reset_strap_values};
            default:           next_rdata = 32'h00000000;
        endcase
    end

    // Read data and acknowledge registered, one cycle after request
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_rdata_o <= 32'h00000000;
            cfg_ack_o   <= 1'b0;
        end else begin
            cfg_rdata_o <= cfg_i.rd ? next_rdata : 32'h00000000;
            cfg_ack_o   <= cfg_i.rd | cfg_i.wr;
        end
    end

    // Window two compare on both buses
    logic host_in_iow2;
    logic pci_in_iow2;

    // RULE1: end field against A[15:4]; RULE2 start field; RULE23 inclusive
    window_match #(.W(12)) u_host_iow2 (
        .value_i  (host_i.addr[15:4]),
        .low_i    (io_window_two[IOW2_START_HI:IOW2_START_LO]),
        .high_i   (io_window_two[IOW2_END_HI:IOW2_END_LO]),
        .inside_o (host_in_iow2)
    );

    window_match #(.W(12)) u_pci_iow2 (
        .value_i  (pci_i.addr[15:4]),
        .low_i    (io_window_two[IOW2_START_HI:IOW2_START_LO]),
        .high_i   (io_window_two[IOW2_END_HI:IOW2_END_LO]),
        .inside_o (pci_in_iow2)
    );

    // Interrupt unit window: base at 1 MB, 4 KB blocks by unit ID
    logic [3:0] unit_low;
    logic [3:0] unit_high;
    logic       host_in_iuw;
    logic       pci_in_iuw;

    assign unit_low  = interrupt_unit_window[IUW_LOW_HI:IUW_LOW_LO];
    assign unit_high = interrupt_unit_window[IUW_HIGH_HI:IUW_HIGH_LO];

    // RULE8: base field matches A[35:20]; upper nibble of offset in 64 KB window
    // RULE9: ID fields bound the block index
    // RULE7: claim blocks low through high, each covering xxx000h-xxxFFFh
    function automatic logic in_unit_window(input logic [35:0] a,
                                            input logic [31:0] r,
                                            input logic [3:0]  lo,
                                            input logic [3:0]  hi);
        logic base_hit;
        base_hit = (a[35:20] == r[IUW_BASE_HI:IUW_BASE_LO]) && (a[19:16] == 4'h0);
        return r[IUW_EN_BIT] && base_hit && (a[15:12] >= lo) && (a[15:12] <= hi);
    endfunction : in_unit_window

    assign host_in_iuw = in_unit_window(host_i.addr, interrupt_unit_window,
                                        unit_low, unit_high);
    assign pci_in_iuw  = in_unit_window(pci_i.addr, interrupt_unit_window,
                                        unit_low, unit_high);

    // Host side forwarding decision
    logic next_host_fwd;
    always_comb begin
        if (host_i.is_io) begin
            // RULE3: enable bit picks direction inside window two
            if (host_in_iow2) begin
                next_host_fwd = io_window_two[IOW2_EN_BIT];
            end else begin
                // RULE4: default I/O ownership by role
                next_host_fwd = !IS_AUX;
            end
        end else begin
            // RULE10: enabled unit window claimed toward PCI
            next_host_fwd = host_in_iuw;
        end
    end

    // PCI side mirrors host for I/O only: forward to host where host side ignores; memory never forwarded
    logic next_pci_fwd;
    always_comb begin
        if (pci_i.is_io) begin
            // RULE3: enable 0 forwards PCI accesses in window two
            if (pci_in_iow2) begin
                next_pci_fwd = !io_window_two[IOW2_EN_BIT];
            end else begin
                // RULE4: auxiliary forwards PCI I/O outside windows
                next_pci_fwd = IS_AUX;
            end
        end else begin
            // Memory in the unit window belongs to PCI; others left to other ranges
            next_pci_fwd = 1'b0;
        end
    end

    // Decisions registered: one cycle from query to answer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            host_to_pci_o <= 1'b0;
            host_done_o   <= 1'b0;
        end else begin
            host_to_pci_o <= host_i.valid & next_host_fwd;
            host_done_o   <= host_i.valid;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pci_to_host_o <= 1'b0;
            pci_done_o    <= 1'b0;
        end else begin
            pci_to_host_o <= pci_i.valid & next_pci_fwd & ~pci_in_iuw;
            pci_done_o    <= pci_i.valid;
        end
    end

    // Strap drive while host reset is held; power-on reset drives the defaults
    // Hard reset arrives from the reset controller on this clock, no synchroniser
    // RULE16: cluster ID lines; RULE17 bit 10; RULE18 bit 9; RULE19 bit 8
    // RULE20: queue depth; RULE21 reset vector; RULE22 redundancy check mode
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // RULE13: defaults driven throughout power-on reset
            strap_addr_o    <= STRAP_RESET[STRAP_HI:STRAP_LO];
            strap_addr_oe_o <= HAS_STRAP ? 8'hFF : 8'h00;
        end else begin
            // RULE14: programmed contents driven while host reset asserted
            strap_addr_o    <= reset_strap_values[STRAP_HI:STRAP_LO];
            strap_addr_oe_o <= (HAS_STRAP && hard_reset_i) ? 8'hFF : 8'h00;
        end
    end

endmodule : range_decode_cfg

// File: core/window_match.sv
// Window comparator: inclusive range test of an address field
`timescale 1ns/100ps
module window_match
    import range_cfg_pkg::*;
#(
    parameter int W = 12
) (
    // Compared value and limits
    input  wire logic [W-1:0] value_i,
    input  wire logic [W-1:0] low_i,
    input  wire logic [W-1:0] high_i,
    // Result
    output logic              inside_o
);

    // Inclusive on both ends; an inverted range matches nothing
    assign inside_o = (value_i >= low_i) && (value_i <= high_i);

endmodule : window_match

// File: verification/host_strap_sampler.sv
// Partner: host bus agents latching the strap lines as host reset ends
`timescale 1ns/100ps
module host_strap_sampler (
    // Clock and host reset
    input  wire logic        clk_i,
    input  wire logic        hard_reset_i,
    // Strap lines from the bridge
    input  wire logic [12:5] strap_addr_i,
    input  wire logic [12:5] strap_addr_oe_i,
    // Values the agents took
    output logic      [12:5] captured_o
);
    logic [12:5] line;
    logic        held;
    // Undriven lines float to the terminated high level, so a lost enable shows
    // line levels
    assign line = (strap_addr_i & strap_addr_oe_i) | ~strap_addr_oe_i;
    always_ff @(posedge clk_i) begin
        held <= hard_reset_i;
        if (held && !hard_reset_i) begin
            captured_o <= line;
        end
    end
endmodule : host_strap_sampler

// File: verification/range_decode_cfg_assertions.sv
// Checker: timing and cause relations at the range decode block ports
`timescale 1ns/100ps
module range_decode_cfg_checker
    import range_cfg_pkg::*;
#(
    parameter bridge_role_t ROLE = BRIDGE_COMPAT
) (
    // Clock and resets
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        hard_reset_i,
    // Register access
    input wire cfg_req_t    cfg_i,
    input wire logic        cfg_ack_o,
    // Decode queries and answers
    input wire dec_req_t    host_i,
    input wire logic        host_to_pci_o,
    input wire logic        host_done_o,
    input wire dec_req_t    pci_i,
    input wire logic        pci_to_host_o,
    input wire logic        pci_done_o,
    // Strap lines
    input wire logic [12:5] strap_addr_o,
    input wire logic [12:5] strap_addr_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Answers land one cycle after the request, never without one
    ack_on_time_a: assert property ((cfg_i.rd || cfg_i.wr) |=> cfg_ack_o)
        else $error("ack missing");
    ack_has_cause_a: assert property (cfg_ack_o |-> $past(cfg_i.rd || cfg_i.wr))
        else $error("ack without request");
    host_answer_a: assert property (!$past(reset_i) |-> host_done_o == $past(host_i.valid))
        else $error("host done wrong");
    pci_answer_a: assert property (!$past(reset_i) |-> pci_done_o == $past(pci_i.valid))
        else $error("pci done wrong");
    // PCI memory accesses are never forwarded by this block
    pci_io_only_a: assert property (pci_to_host_o |-> pci_done_o && $past(pci_i.is_io))
        else $error("pci forward without io query");
    // Drive enable trails the host reset by one cycle
    oe_follows_reset_a: assert property (ROLE != BRIDGE_AUX && !$past(reset_i) |->
        strap_addr_oe_o == {8{$past(hard_reset_i)}}) else $error("strap enable wrong");
    aux_no_drive_a: assert property (ROLE == BRIDGE_AUX |-> strap_addr_oe_o == 8'h00)
        else $error("aux drives straps");
    strap_hold_a: assert property (!$past(cfg_i.wr) && !$past(cfg_i.wr, 2) |->
        $stable(strap_addr_o)) else $error("strap changed without write");
endmodule : range_decode_cfg_checker

bind range_decode_cfg range_decode_cfg_checker #(.ROLE(ROLE)) chk_u (
    .clk_i(clk_i), .reset_i(reset_i), .hard_reset_i(hard_reset_i), .cfg_i(cfg_i),
    .cfg_ack_o(cfg_ack_o), .host_i(host_i), .host_to_pci_o(host_to_pci_o),
    .host_done_o(host_done_o), .pci_i(pci_i), .pci_to_host_o(pci_to_host_o),
    .pci_done_o(pci_done_o), .strap_addr_o(strap_addr_o), .strap_addr_oe_o(strap_addr_oe_o));

// File: verification/range_decode_cfg_tb.sv
// Testbench: registers, window decode and strap drive of compat and aux bridges
`timescale 1ns/100ps
module range_decode_cfg_tb;
    import range_cfg_pkg::*;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        hard_reset_i = 1'b0;
    cfg_req_t    cfg_i = '0;
    dec_req_t    host_i = '0;
    dec_req_t    pci_i = '0;
    logic [31:0] rdata, ardata;
    logic        ack, h2p, ah2p, p2h, ap2h, hdone, pdone;
    logic [12:5] strap, strap_oe, astrap_oe, captured;
    int          miscompares = 0;
    int          checks = 0;
    always #10 clk_i = ~clk_i;
    // both bridges see the same configuration writes, as a dual system requires
    range_decode_cfg #(.ROLE(BRIDGE_COMPAT)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
        .hard_reset_i(hard_reset_i), .cfg_i(cfg_i), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
        .host_i(host_i), .host_to_pci_o(h2p), .host_done_o(hdone), .pci_i(pci_i),
        .pci_to_host_o(p2h), .pci_done_o(pdone), .strap_addr_o(strap),
        .strap_addr_oe_o(strap_oe));
    range_decode_cfg #(.ROLE(BRIDGE_AUX)) aux_u (.clk_i(clk_i), .reset_i(reset_i),
        .hard_reset_i(hard_reset_i), .cfg_i(cfg_i), .cfg_rdata_o(ardata), .cfg_ack_o(),
        .host_i(host_i), .host_to_pci_o(ah2p), .host_done_o(), .pci_i(pci_i),
        .pci_to_host_o(ap2h), .pci_done_o(), .strap_addr_o(), .strap_addr_oe_o(astrap_oe));
    host_strap_sampler agent_u (.clk_i(clk_i), .hard_reset_i(hard_reset_i),
        .strap_addr_i(strap), .strap_addr_oe_i(strap_oe), .captured_o(captured));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) #1;
        cfg_i = '{rd: 1'b0, wr: 1'b1, addr: a, be: 4'hF, wdata: d};
        @(posedge clk_i) #1;
        cfg_i = '0;
    endtask : wr
    // Read both bridges; data stands only in the ack cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] ae);
        @(posedge clk_i) #1;
        cfg_i = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge clk_i) #1;
        cfg_i = '0;
        chk({ack, rdata}, {1'b1, e});
        chk(ardata, ae);
    endtask : rd
    // Same query on both buses; e holds compat host, compat pci, aux host, aux pci
    task automatic q(input logic io, input logic [35:0] a, input logic [3:0] e);
        @(posedge clk_i) #1;
        host_i = '{valid: 1'b1, is_io: io, addr: a};
        pci_i = '{valid: 1'b1, is_io: io, addr: a};
        @(posedge clk_i) #1;
        host_i = '0;
        pci_i = '0;
        chk({h2p, p2h, ah2p, ap2h}, e);
        chk({hdone, pdone}, 2'b11);
    endtask : q
    task automatic t_defaults;
        rd(8'hA0, 32'hFFF00001, 32'hFFF00000);
        rd(8'hA4, 32'h00FEC001, 32'h00FEC000);
        rd(8'hB0, 32'h0, 32'h0);
        rd(8'hC0, 32'h0, 32'h0);
        q(1'b1, 36'h00000ABC0, 4'b1001);
    endtask : t_defaults
    task automatic t_io_window;
        wr(8'hA0, 32'hFFFFFFFF);
        rd(8'hA0, 32'hFFF0FFF1, 32'hFFF0FFF1);
        wr(8'hA0, 32'h1FF01000);
        q(1'b1, 36'h000001000, 4'b0101);
        q(1'b1, 36'h000001FF0, 4'b0101);
        q(1'b1, 36'h000000FF0, 4'b1001);
        q(1'b1, 36'h000002000, 4'b1001);
        wr(8'hA0, 32'h1FF01001);
        q(1'b1, 36'h000001FF8, 4'b1010);
    endtask : t_io_window
    // units 2..5 contiguous inside one 64 KB window
    // both bridges share one base address
    task automatic t_unit_window;
        wr(8'hA4, 32'h00FEC251);
        q(1'b0, 36'h0FEC02000, 4'b1010);
        q(1'b0, 36'h0FEC05FFF, 4'b1010);
        q(1'b0, 36'h0FEC01FFF, 4'b0000);
        q(1'b0, 36'h0FEC06000, 4'b0000);
        q(1'b0, 36'h0FEC13000, 4'b0000);
        q(1'b0, 36'h0FED03000, 4'b0000);
        wr(8'hA4, 32'h00FEC250);
        q(1'b0, 36'h0FEC03000, 4'b0000);
        wr(8'hA4, 32'hFFFFFFFF);
        rd(8'hA4, 32'h0FFFFFF1, 32'h0FFFFFF1);
    endtask : t_unit_window
    // Program straps, run a host reset, see lines and what agents took
    task automatic t_strap(input logic [15:0] p, input logic [7:0] v);
        wr(8'hB0, {16'h0, p});
        rd(8'hB0, {16'h0, p}, 32'h0);
        hard_reset_i = 1'b1;
        repeat (2) @(posedge clk_i) #1;
        chk({strap_oe, strap, astrap_oe}, {8'hFF, v, 8'h00});
        hard_reset_i = 1'b0;
        repeat (2) @(posedge clk_i) #1;
        chk({strap_oe, captured}, {8'h00, v});
        rd(8'hB0, {16'h0, p}, 32'h0);
    endtask : t_strap
    task automatic t_power_on;
        @(posedge clk_i) #1;
        reset_i = 1'b1;
        @(posedge clk_i) #1;
        chk({strap_oe, strap, astrap_oe}, {8'hFF, 8'h00, 8'h00});
        reset_i = 1'b0;
        rd(8'hB0, 32'h0, 32'h0);
        rd(8'hA0, 32'hFFF00001, 32'hFFF00000);
    endtask : t_power_on
    task automatic final_report;
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge clk_i);
        #1 reset_i = 1'b0;
        t_defaults();
        t_io_window();
        t_unit_window();
        wr(8'hB0, 32'h0000FFFF);
        rd(8'hB0, 32'h00001FE0, 32'h0);
        t_strap(16'h1540, 8'hAA);
        t_strap(16'h0AA0, 8'h55);
        t_power_on();
        final_report();
    end
    // Tests need well under a thousand cycles; this limit only catches a hang
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule : range_decode_cfg_tb
